/* File: src/adcc_map.svh */
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
`define ADCC_ADDR_CONTROL     8'hc5
`define ADCC_ADDR_RESULT_HIGH 8'hc3
`define ADCC_ADDR_RESULT_LOW  8'hc2
`define ADCC_BIT_DONE         7
`define ADCC_BIT_CONT         6
`define ADCC_BIT_IRQ_EN       5
`define ADCC_BIT_OVERRUN      4
`define ADCC_CONTROL_RESET    4'h0
`define ADCC_CONV_CYCLES      224
`define ADCC_SEL_DIFF_BASE    4'h8
`define ADCC_SEL_REFERENCE    4'hc
`endif

/* File: src/adcc_pkg.sv */
package adcc_pkg;
  typedef enum logic [1:0] {ADCC_SRC_INPUT, ADCC_SRC_COMMON, ADCC_SRC_REF_POS, ADCC_SRC_REF_NEG} adcc_src_kind_t;
  typedef struct packed {
    adcc_src_kind_t kind;
    logic [2:0]     index;
  } adcc_src_t;
  typedef struct packed {
    adcc_src_t pos;
    adcc_src_t neg;
  } adcc_route_t;
  typedef struct packed {
    logic [11:0] code;
  } adcc_sample_t;
endpackage

/* File: src/adcc_skid.sv */
module adcc_skid
  import adcc_pkg::*;
#(
  parameter int WIDTH = 12
)(
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] slot [2];
  logic [WIDTH-1:0] next_slot [2];
  logic [1:0]       count;
  logic [1:0]       next_count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o  = slot[0];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    next_slot  = slot;
    next_count = count;
    if (pop)
    begin
      next_slot[0] = slot[1];
    end
    if (push)
    begin
      next_slot[(pop ? count - 2'h1 : count) == 2'h0 ? 0 : 1] = in_data_i;
    end
    next_count = count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      slot[0] <= '0;
      slot[1] <= '0;
      count   <= 2'h0;
    end
    else
    begin
      slot  <= next_slot;
      count <= next_count;
    end
  end
endmodule

/* File: src/adcc_top.sv */
`include "adcc_map.svh"
module adcc_top
  import adcc_pkg::*;
#(
  parameter int CONV_CYCLES = `ADCC_CONV_CYCLES
)(
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic        sfr_wr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        sfr_rd_i,
  output logic      [7:0]  sfr_rdata_o,
  output logic             irq3_o,
  output adcc_route_t      route_o,
  output logic             sample_start_o,
  input  wire logic        sample_valid_i,
  output logic             sample_ready_o,
  input  wire logic [11:0] sample_code_i,
  output logic             converting_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {ST_IDLE, ST_CONV} adcc_state_t;

  localparam int CW = $clog2(CONV_CYCLES + 1);

  adcc_state_t  state;
  adcc_state_t  next_state;
  logic [CW-1:0] cycle;
  logic [CW-1:0] next_cycle;
  logic         conv_done_flag;
  logic         next_conv_done_flag;
  logic         overrun_flag;
  logic         next_overrun_flag;
  logic         continuous_mode_bit;
  logic         next_continuous_mode_bit;
  logic         done_irq_enable;
  logic         next_done_irq_enable;
  logic [3:0]   input_select;
  logic [3:0]   next_input_select;
  logic [11:0]  result;
  logic [11:0]  next_result;
  logic         irq_pulse;
  logic         next_irq_pulse;
  logic         start_pulse;
  logic         next_start_pulse;
  adcc_route_t  route;
  adcc_route_t  next_route;
  logic         ctrl_write;
  logic         high_read;
  logic         conv_end;
  logic         buf_valid;
  logic [11:0]  buf_code;

  assign ctrl_write = sfr_wr_i && (sfr_addr_i == `ADCC_ADDR_CONTROL);
  assign high_read  = sfr_rd_i && (sfr_addr_i == `ADCC_ADDR_RESULT_HIGH);

  // ----------------------------------------------------------------
  // result buffer from the front end
  // ----------------------------------------------------------------
  // converter code is held until the conversion window closes, so a fast
  // front end never drops a word; the buffer stalls it instead
  adcc_skid #(
    .WIDTH (12)
  ) u_skid (
    .mclk_i      (mclk_i),
    .reset_i     (reset_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .in_data_i   (sample_code_i),
    .out_valid_o (buf_valid),
    .out_ready_i (conv_end),
    .out_data_o  (buf_code)
  );

  assign conv_end = (state == ST_CONV) && (cycle == CW'(CONV_CYCLES - 1)) && buf_valid;

  // ----------------------------------------------------------------
  // input routing
  // ----------------------------------------------------------------
  always_comb
  begin
    next_route = route;
    if (!input_select[3])
    begin
      next_route.pos = '{ADCC_SRC_INPUT, input_select[2:0]};
      next_route.neg = '{ADCC_SRC_COMMON, 3'h0};
    end
    else if (input_select < `ADCC_SEL_REFERENCE)
    begin
      next_route.pos = '{ADCC_SRC_INPUT, {input_select[1:0], 1'b1}};
      next_route.neg = '{ADCC_SRC_INPUT, {input_select[1:0], 1'b0}};
    end
    else
    begin
      // codes above 12 are undefined; treated as the reference pair
      next_route.pos = '{ADCC_SRC_REF_POS, 3'h0};
      next_route.neg = '{ADCC_SRC_REF_NEG, 3'h0};
    end
  end

  // registered so the multiplexer settles one cycle after a select change
  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      route <= '0;
    end
    else
    begin
      route <= next_route;
    end
  end

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  always_comb
  begin
    next_continuous_mode_bit = continuous_mode_bit;
    next_done_irq_enable     = done_irq_enable;
    next_input_select        = input_select;

    if (ctrl_write)
    begin
      next_continuous_mode_bit = sfr_wdata_i[`ADCC_BIT_CONT];
      next_done_irq_enable     = sfr_wdata_i[`ADCC_BIT_IRQ_EN];
      next_input_select        = sfr_wdata_i[3:0];
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      continuous_mode_bit <= 1'b0;
      done_irq_enable     <= 1'b0;
      input_select        <= `ADCC_CONTROL_RESET;
    end
    else
    begin
      continuous_mode_bit <= next_continuous_mode_bit;
      done_irq_enable     <= next_done_irq_enable;
      input_select        <= next_input_select;
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // a write always wins the state and count, but a window end in the same
  // cycle still loads the old result, sets the done flag and pulses irq3_o when done_irq_enable is set
  always_comb
  begin
    next_state       = state;
    next_cycle       = cycle;
    next_start_pulse = 1'b0;

    // count the window
    // holding at the last count keeps the window shut until the front end
    // delivers; a late sample stretches the conversion instead of losing it
    if (state == ST_CONV && cycle != CW'(CONV_CYCLES - 1))
    begin
      next_cycle = cycle + CW'(1);
    end

    if (conv_end)
    begin
      if (continuous_mode_bit)
      begin
        next_cycle       = '0;
        next_start_pulse = 1'b1;
      end
      else
      begin
        next_state = ST_IDLE;
      end
    end

    if (ctrl_write)
    begin
      next_state       = ST_CONV;
      next_cycle       = '0;
      next_start_pulse = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state       <= ST_IDLE;
      cycle       <= '0;
      start_pulse <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      cycle       <= next_cycle;
      start_pulse <= next_start_pulse;
    end
  end

  // ----------------------------------------------------------------
  // flags and result
  // ----------------------------------------------------------------
  always_comb
  begin
    next_conv_done_flag = conv_done_flag;
    next_overrun_flag   = overrun_flag;
    next_result         = result;
    next_irq_pulse      = 1'b0;

    if (high_read)
    begin
      next_conv_done_flag = 1'b0;
      next_overrun_flag   = 1'b0;
    end

    // an end in the cycle of a high read loses nothing: the fresh result
    // is never reported as already read
    if (conv_end)
    begin
      // code kept as two's complement, newest wins
      next_result = buf_code;
      if (conv_done_flag)
      begin
        next_overrun_flag = 1'b1;
      end
      next_conv_done_flag = 1'b1;
      next_irq_pulse = done_irq_enable;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      conv_done_flag <= 1'b0;
      overrun_flag   <= 1'b0;
      result         <= '0;
      irq_pulse      <= 1'b0;
    end
    else
    begin
      conv_done_flag <= next_conv_done_flag;
      overrun_flag   <= next_overrun_flag;
      result         <= next_result;
      irq_pulse      <= next_irq_pulse;
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always_comb
  begin
    // read data follows the address with no strobe, so only the high
    // byte strobe has a side effect
    unique case (sfr_addr_i)
      `ADCC_ADDR_CONTROL:
        sfr_rdata_o = {conv_done_flag, continuous_mode_bit, done_irq_enable, overrun_flag, input_select};
      `ADCC_ADDR_RESULT_HIGH:
        sfr_rdata_o = result[11:4];
      `ADCC_ADDR_RESULT_LOW:
        sfr_rdata_o = {result[3:0], 4'h0};
      default:
        sfr_rdata_o = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign irq3_o         = irq_pulse;
  assign route_o        = route;
  assign sample_start_o = start_pulse;
  assign converting_o   = (state == ST_CONV);
endmodule

/* File: bench/adcc_chk.sv */
module adcc_chk
  import adcc_pkg::*;
#(
  parameter int CONV_CYCLES = 224
)(
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic [7:0]  sfr_addr_i,
  input wire logic        sfr_wr_i,
  input wire logic [7:0]  sfr_wdata_i,
  input wire logic        sfr_rd_i,
  input wire logic [7:0]  sfr_rdata_o,
  input wire logic        irq3_o,
  input adcc_route_t      route_o,
  input wire logic        sample_start_o,
  input wire logic        sample_ready_o,
  input wire logic        converting_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // cycles since last start
  // ----
  logic [8:0] cnt;
  logic [8:0] next_cnt;
  assign next_cnt = sample_start_o ? 9'h1 : (cnt == 9'h1ff ? cnt : cnt + 9'h1);
  always_ff @(posedge mclk_i or posedge reset_i)
    if (reset_i)
      cnt <= 9'h0;
    else
      cnt <= next_cnt;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_start_on_write: assert property (sfr_wr_i && sfr_addr_i == 8'hc5 |=> sample_start_o)
    else $error("write gave no start");
  a_start_converting: assert property (sample_start_o |-> converting_o)
    else $error("start without conversion");
  a_conv_length: assert property (irq3_o |-> cnt >= CONV_CYCLES)
    else $error("conversion too short");
  a_irq_single: assert property (irq3_o |=> !irq3_o)
    else $error("irq longer than one cycle");
  a_done_with_irq: assert property (irq3_o && sfr_addr_i == 8'hc5 |-> sfr_rdata_o[7])
    else $error("done flag missing at irq");
  a_high_read_clears: assert property ((sfr_rd_i && sfr_addr_i == 8'hc3 && !converting_o) ##1 !converting_o
    ##1 (sfr_addr_i == 8'hc5 && !converting_o) |-> sfr_rdata_o[7] == 1'b0 && sfr_rdata_o[4] == 1'b0)
    else $error("flags not cleared by high read");
  a_route_single: assert property ((sfr_wr_i && sfr_addr_i == 8'hc5 && !sfr_wdata_i[3]) ##1 !sfr_wr_i
    |=> route_o.pos == {ADCC_SRC_INPUT, $past(sfr_wdata_i[2:0], 2)} && route_o.neg.kind == ADCC_SRC_COMMON)
    else $error("single ended route wrong");
  a_low_nibble_zero: assert property (sfr_addr_i == 8'hc2 |-> sfr_rdata_o[3:0] == 4'h0)
    else $error("low result nibble not zero");
  a_unmapped_zero: assert property (!(sfr_addr_i inside {8'hc2, 8'hc3, 8'hc5}) |-> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind adcc_top adcc_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.mclk_i(mclk_i), .reset_i(reset_i),
  .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
  .sfr_rdata_o(sfr_rdata_o), .irq3_o(irq3_o), .route_o(route_o), .sample_start_o(sample_start_o),
  .sample_ready_o(sample_ready_o), .converting_o(converting_o));

/* File: bench/adcc_fe.sv */
module adcc_fe
(
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        sample_start_i,
  input  wire logic        sample_ready_i,
  input  wire logic [3:0]  delay_i,
  input  wire logic [11:0] code_i,
  output logic             sample_valid_o,
  output logic      [11:0] sample_code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // one code per start, held until taken
  // ----
  logic [3:0] pend;
  logic [3:0] cnt;
  logic       launch;
  assign launch = !sample_valid_o && pend != 4'h0 && cnt == 4'h0;
  always_ff @(posedge mclk_i or posedge reset_i)
    if (reset_i)
    begin
      {pend, cnt, sample_valid_o, sample_code_o} <= '0;
    end
    else
    begin
      pend <= pend + {3'h0, sample_start_i} - {3'h0, launch};
      cnt <= sample_start_i ? delay_i : (cnt != 4'h0 ? cnt - 4'h1 : cnt);
      // released data must not look valid
      if (sample_valid_o && sample_ready_i)
        {sample_valid_o, sample_code_o} <= {1'b0, ~sample_code_o};
      else if (launch)
        {sample_valid_o, sample_code_o} <= {1'b1, code_i};
    end
endmodule

/* File: bench/tb.sv */
module tb
  import adcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CC = 8;
  logic        mclk_i = 0, reset_i = 1, wr = 0, rd = 0, irq, start, valid, ready, conv;
  logic [7:0]  addr = 0, wdata = 0, rdata, d;
  logic [11:0] code, fcode = 0;
  logic [3:0]  dly = 0;
  logic [31:0] seed = 32'h1c5c, r;
  adcc_route_t route;
  int          err_total = 0, comparisons = 0;
  adcc_top #(.CONV_CYCLES(CC)) dut (.mclk_i(mclk_i), .reset_i(reset_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .irq3_o(irq), .route_o(route),
    .sample_start_o(start), .sample_valid_i(valid), .sample_ready_o(ready), .sample_code_i(code),
    .converting_o(conv));
  adcc_fe fe (.mclk_i(mclk_i), .reset_i(reset_i), .sample_start_i(start), .sample_ready_i(ready),
    .delay_i(dly), .code_i(fcode), .sample_valid_o(valid), .sample_code_o(code));
  // ----
  // helpers
  // ----
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function adcc_route_t exp_rt(input logic [3:0] s);
    exp_rt = {ADCC_SRC_REF_POS, 3'h0, ADCC_SRC_REF_NEG, 3'h0};
    if (s < 4'h8)
      exp_rt = {ADCC_SRC_INPUT, s[2:0], ADCC_SRC_COMMON, 3'h0};
    else if (s < 4'hc)
      exp_rt = {ADCC_SRC_INPUT, s[1:0], 1'b1, ADCC_SRC_INPUT, s[1:0], 1'b0};
  endfunction
  // only input sources carry a meaningful index
  function adcc_route_t norm(input adcc_route_t x);
    norm = x;
    if (x.pos.kind != ADCC_SRC_INPUT)
      norm.pos.index = 3'h0;
    if (x.neg.kind != ADCC_SRC_INPUT)
      norm.neg.index = 3'h0;
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task acc(input logic [7:0] a, input logic [7:0] v, input bit w);
    @(negedge mclk_i);
    {addr, wdata, wr, rd} = {a, v, w, !w};
    #1 d = rdata;
    @(negedge mclk_i);
    {wr, rd} = 2'b00;
  endtask
  task wait_ev(input bit on_irq);
    int n;
    n = 0;
    do
    begin
      @(negedge mclk_i);
      n++;
    end while ((on_irq ? irq : !conv) !== 1'b1 && n < 300);
    chk(n < 300, 1);
  endtask
  task give_verdict;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever #20 mclk_i = ~mclk_i;
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    give_verdict;
  end
  // ----
  // scenarios
  // ----
  initial
  begin
    repeat (12) @(posedge mclk_i);
    @(negedge mclk_i) reset_i = 0;
    acc(8'hc5, 8'h00, 0);
    chk(d, 8'h00);
    for (int s = 0; s < 16; s++)
    begin
      r = xs();
      {dly, fcode} = r[15:0];
      acc(8'hc5, {4'h2, s[3:0]}, 1);
      wait_ev(1);
      chk(norm(route), norm(exp_rt(s[3:0])));
      acc(8'hc2, 8'h00, 0);
      chk(d, {fcode[3:0], 4'h0});
      acc(8'hc5, 8'h00, 0);
      chk(d, {4'ha, s[3:0]});
      acc(8'hc3, 8'h00, 0);
      chk(d, fcode[11:4]);
      acc(8'hc5, 8'h00, 0);
      chk(d, {4'h2, s[3:0]});
    end
    acc(8'hc5, 8'h60, 1);
    wait_ev(1);
    r = xs();
    fcode = r[11:0];
    wait_ev(1);
    acc(8'hc5, 8'h00, 0);
    chk(d, 8'hf0);
    acc(8'hc3, 8'h00, 0);
    chk(d, fcode[11:4]);
    acc(8'hc5, 8'h00, 1);
    wait_ev(0);
    chk(irq, 0);
    for (int i = 0; i < 3 * CC; i++)
    begin
      @(negedge mclk_i);
      chk(conv, 0);
    end
    acc(8'hc3, 8'h00, 0);
    acc(8'hc5, 8'h9c, 1);
    acc(8'hc5, 8'h00, 0);
    chk(d, 8'h0c);
    wait_ev(0);
    acc(8'hc5, 8'h0c, 1);
    acc(8'hc5, 8'h00, 0);
    chk(d, 8'h8c);
    dly = 0;
    repeat (3) acc(8'hc5, 8'h00, 1);
    repeat (4) @(negedge mclk_i);
    chk(ready, 0);
    // mid-run reset with continuous conversions running
    acc(8'hc5, 8'h40, 1);
    @(negedge mclk_i) reset_i = 1;
    @(negedge mclk_i) reset_i = 0;
    acc(8'hc5, 8'h00, 0);
    chk({conv, ready, d}, {2'b01, 8'h00});
    // most negative code after reset
    fcode = 12'h800;
    acc(8'hc5, 8'h2c, 1);
    wait_ev(1);
    acc(8'hc3, 8'h00, 0);
    chk(d, 8'h80);
    give_verdict;
  end
endmodule
